// ### hw/scg_clock_gen.sv
// Clock generator top: source decode, start-up timing, divider, gating
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "scg_map.svh"
// Overview of operation
// - Source class decodes from 4-bit select: crystal, low-freq, RCs, ext.
// - A stored one in a configuration bit means unprogrammed, zero programmed.
// - Wake from power-down or power-save waits a source-cycle count first.
// - Reset adds 4,096 or 65,536 watchdog oscillator cycles before running.
// - Core clock gating stops all core execution.
// - Peripheral clock feeds timers; async external interrupt still wakes.
// - Two-wire address match wakes the device in every sleep mode.
// - Program store clock runs together with the core clock.
// - Async timer clock follows the 32 kHz crystal, running in sleep except power-down and standby.
// - Converter clock stays active in converter noise-reduction sleep.
// - Clock domains are gated per selected sleep mode.
// - Divider divides the source by any factor from 2 to 129.
// - Divide enable divides core, peripheral, converter, program clocks.
// - Divide enable may be written at any time while running.
// - Divided frequency equals source over 129 minus factor.
// - Factor is taken only when written together with enable set.
module scg_clock_gen #(
  parameter logic [16:0] RST_DLY_SHORT = `SCG_RST_DLY_SHORT,
  parameter logic [16:0] RST_DLY_LONG = `SCG_RST_DLY_LONG,
  parameter logic [15:0] STARTUP_XTAL = `SCG_SU_XTAL
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] source_select_field,
  input wire logic reset_delay_fuse,
  input wire logic wdt_osc_pin,
  input wire logic xtal32_pin,
  input wire logic ext_int_async_pin,
  input wire logic twi_addr_match_pin,
  output logic core_clock_tick,
  output logic peripheral_clock_tick,
  output logic program_store_clock_tick,
  output logic converter_clock_tick,
  output logic async_timer_clock_tick,
  output logic execution_enable
);
  import scg_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    scg_state_e st;
    logic fuse_taken;
    logic [3:0] src_sel;
    logic long_dly;
    logic [15:0] su_cnt;
    logic [7:0] divctl;
    logic [2:0] mode;
    logic [2:0][2:0] sync;
    logic [2:0] lvl;
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [7:0] wbyte;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic core_t;
    logic io_t;
    logic fl_t;
    logic adc_t;
    logic asy_t;
    logic exec;
  } scg_top_s;

  scg_top_s q, n;
  scg_ctl_if ctl();
  logic [2:0] pins;
  logic [4:0] en;
  logic [15:0] su_lim;
  logic sleep_go;
  logic wake;
  logic x_rise;

  // ==========================================================
  // Helpers
  scg_divider u_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ctl(ctl.div)
  );

  scg_wdt_timer #(
    .LIM_SHORT(RST_DLY_SHORT),
    .LIM_LONG(RST_DLY_LONG)
  ) u_wdt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wdt_osc_pin(wdt_osc_pin),
    .ctl(ctl.wdt)
  );

  assign ctl.div_en = q.divctl[`SCG_DIV_EN_BIT];
  assign ctl.div_factor = q.divctl[6:0];
  assign ctl.wdt_start = q.fuse_taken && (q.st == ST_RST_DLY);
  assign ctl.wdt_long = q.long_dly;
  assign pins = {twi_addr_match_pin, ext_int_async_pin, xtal32_pin};

  function automatic scg_src_e src_class(input logic [3:0] s);
    if (s >= 4'ha) begin
      return SRC_XTAL;
    end else if (s == 4'h9) begin
      return SRC_LF_XTAL;
    end else if (s >= 4'h5) begin
      return SRC_EXT_RC;
    end else if (s >= 4'h1) begin
      return SRC_INT_RC;
    end
    return SRC_EXT_CLK;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    sleep_go = 1'b0;

    // Pin synchronisers: a change counts once stages two and three agree
    for (int i = 0; i < 3; i++) begin
      n.sync[i] = {q.sync[i][1:0], pins[i]};
      if (q.sync[i][1] == q.sync[i][2]) begin
        n.lvl[i] = q.sync[i][2];
      end
    end
    x_rise = n.lvl[0] && !q.lvl[0];

    // Either async source wakes; the address match needs no peripheral
    // clock, so it works in every sleep mode.
    wake = q.lvl[1] || q.lvl[2];

    // Start-up length depends on how slowly the source settles
    case (src_class(q.src_sel))
      SRC_XTAL: begin
        su_lim = STARTUP_XTAL;
      end
      SRC_LF_XTAL: begin
        su_lim = `SCG_SU_LF;
      end
      default: begin
        su_lim = `SCG_SU_RC;
      end
    endcase

    // ----- register bus: write path
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wbyte = s_axi_wdata[7:0];
      n.wlane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `SCG_RESP_OKAY;
      case (q.awaddr)
        `SCG_ADDR_DIVCTL: begin
          if (q.wlane) begin
            // Enable may flip at any time; the divider retimes it
            n.divctl[`SCG_DIV_EN_BIT] = q.wbyte[`SCG_DIV_EN_BIT];
            if (q.wbyte[`SCG_DIV_EN_BIT]) begin
              n.divctl[6:0] = q.wbyte[6:0];
            end
          end
        end
        `SCG_ADDR_SLEEP: begin
          if (q.wlane) begin
            n.mode = q.wbyte[2:0];
            sleep_go = q.wbyte[`SCG_SLEEP_GO_BIT];
          end
        end
        `SCG_ADDR_STATUS: begin
          n.bresp = `SCG_RESP_OKAY;
        end
        default: begin
          n.bresp = `SCG_RESP_SLVERR;
        end
      endcase
    end

    // ----- register bus: read path
    if (s_axi_rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `SCG_RESP_OKAY;
      case (s_axi_araddr)
        `SCG_ADDR_DIVCTL: begin
          n.rdata = {24'h00_0000, q.divctl};
        end
        `SCG_ADDR_SLEEP: begin
          n.rdata = {29'h0000_0000, q.mode};
        end
        `SCG_ADDR_STATUS: begin
          n.rdata = {24'h00_0000, q.lvl, src_class(q.src_sel), q.st};
        end
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = `SCG_RESP_SLVERR;
        end
      endcase
    end

    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;

    // ----- start-up and sleep sequencing
    case (q.st)
      ST_RST_DLY: begin
        if (!q.fuse_taken) begin
          // Configuration bits are caught once, after reset release
          n.fuse_taken = 1'b1;
          n.src_sel = source_select_field;
          n.long_dly = !reset_delay_fuse;
        end else if (ctl.wdt_done) begin
          n.st = ST_WAKE;
          n.su_cnt = 16'h0000;
        end
      end
      ST_WAKE: begin
        if (q.su_cnt == su_lim - 16'h0001) begin
          n.st = ST_RUN;
        end else begin
          n.su_cnt = q.su_cnt + 16'h0001;
        end
      end
      ST_RUN: begin
        if (sleep_go) begin
          n.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          case (scg_sleep_e'(q.mode))
            SM_PWR_DOWN, SM_PWR_SAVE: begin
              n.st = ST_WAKE;
              n.su_cnt = 16'h0000;
            end
            default: begin
              n.st = ST_RUN;
            end
          endcase
        end
      end
      default: begin
        n.st = ST_RST_DLY;
      end
    endcase

    // ----- domain gating, bits are {async, conv, prog, periph, core}
    case (q.st)
      ST_RUN: begin
        en = 5'h1f;
      end
      ST_SLEEP: begin
        case (scg_sleep_e'(q.mode))
          SM_IDLE: begin
            en = 5'h1a;
          end
          SM_ADC_NR: begin
            en = 5'h18;
          end
          SM_PWR_SAVE, SM_EXT_STANDBY: begin
            en = 5'h10;
          end
          default: begin
            en = 5'h00;
          end
        endcase
      end
      default: begin
        en = 5'h00;
      end
    endcase

    // All synchronous domains share the divided tick
    n.core_t = ctl.div_tick && en[0];
    n.io_t = ctl.div_tick && en[1];
    n.fl_t = ctl.div_tick && en[2] && en[0];
    n.adc_t = ctl.div_tick && en[3];
    // The async timer never sees the divider: it follows its crystal
    n.asy_t = x_rise && en[4];
    n.exec = en[0];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign core_clock_tick = q.core_t;
  assign peripheral_clock_tick = q.io_t;
  assign program_store_clock_tick = q.fl_t;
  assign converter_clock_tick = q.adc_t;
  assign async_timer_clock_tick = q.asy_t;
  assign execution_enable = q.exec;
endmodule

// ### hw/scg_map.svh
// Register map, field positions and timing counts of the clock generator
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define SCG_ADDR_DIVCTL 4'h0
`define SCG_ADDR_SLEEP 4'h4
`define SCG_ADDR_STATUS 4'h8
// ==========================================================
// Fields
`define SCG_DIV_EN_BIT 7
`define SCG_DIV_BASE 8'h81
`define SCG_SLEEP_GO_BIT 3
// ==========================================================
// Start-up counts, in source or watchdog oscillator cycles
`define SCG_SU_XTAL 16'h4000
`define SCG_SU_LF 16'h0400
`define SCG_SU_RC 16'h0006
`define SCG_RST_DLY_SHORT 17'h0_1000
`define SCG_RST_DLY_LONG 17'h1_0000
// ==========================================================
// Bus answers
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2
`endif

// ### hw/scg_pkg.sv
// Types shared by the clock generator modules
package scg_pkg;
  typedef enum logic [2:0] {
    SM_IDLE, SM_ADC_NR, SM_PWR_DOWN, SM_PWR_SAVE, SM_STANDBY,
    SM_EXT_STANDBY
  } scg_sleep_e;
  typedef enum logic [2:0] {
    SRC_XTAL, SRC_LF_XTAL, SRC_EXT_RC, SRC_INT_RC, SRC_EXT_CLK
  } scg_src_e;
  typedef enum logic [1:0] {
    ST_RST_DLY, ST_WAKE, ST_RUN, ST_SLEEP
  } scg_state_e;
endpackage

// ### hw/scg_ctl_if.sv
// Control signals between the clock generator top and its helpers
`timescale 1ns/10ps
interface scg_ctl_if;
  logic div_en;
  logic [6:0] div_factor;
  logic div_tick;
  logic wdt_start;
  logic wdt_long;
  logic wdt_done;
  modport div(input div_en, input div_factor, output div_tick);
  modport wdt(input wdt_start, input wdt_long, output wdt_done);
  modport top(output div_en, output div_factor, input div_tick,
              output wdt_start, output wdt_long, input wdt_done);
endinterface

// ### hw/scg_divider.sv
// Glitch-free programmable divider producing the system clock tick
`timescale 1ns/10ps
`include "scg_map.svh"
module scg_divider (
  input wire logic clk_sys,
  input wire logic sys_rst,
  scg_ctl_if.div ctl
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } scg_div_s;
  scg_div_s q, n;
  logic [7:0] period;
  // A new factor is only looked at on a period boundary, so no tick
  // spacing ever comes out shorter than one source cycle.
  always_comb begin
    n = q;
    period = 8'h01;
    if (ctl.div_en) begin
      period = `SCG_DIV_BASE - {1'b0, ctl.div_factor};
    end
    if (q.cnt == 8'h00) begin
      n.tick = 1'b1;
      n.cnt = period - 8'h01;
    end else begin
      n.tick = 1'b0;
      n.cnt = q.cnt - 8'h01;
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign ctl.div_tick = q.tick;
endmodule

// ### hw/scg_wdt_timer.sv
// Reset delay counted on the watchdog oscillator pin
`timescale 1ns/10ps
`include "scg_map.svh"
module scg_wdt_timer #(
  parameter logic [16:0] LIM_SHORT = `SCG_RST_DLY_SHORT,
  parameter logic [16:0] LIM_LONG = `SCG_RST_DLY_LONG
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wdt_osc_pin,
  scg_ctl_if.wdt ctl
);
  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic [16:0] cnt;
    logic done;
  } scg_wdt_s;
  scg_wdt_s q, n;
  logic [16:0] lim;
  always_comb begin
    n = q;
    n.sync = {q.sync[1:0], wdt_osc_pin};
    if (q.sync[1] == q.sync[2]) begin
      n.lvl = q.sync[2];
    end
    lim = ctl.wdt_long ? LIM_LONG : LIM_SHORT;
    // Falls are counted: a pin already high at reset release would
    // otherwise show up as a false first rise and cut the delay short
    if (!ctl.wdt_start) begin
      n.cnt = 17'h0_0000;
      n.done = 1'b0;
    end else if (!n.lvl && q.lvl && !q.done) begin
      if (q.cnt == lim - 17'h0_0001) begin
        n.done = 1'b1;
      end else begin
        n.cnt = q.cnt + 17'h0_0001;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign ctl.wdt_done = q.done;
endmodule

// ### verification/scg_osc_model.sv
// Watchdog oscillator and 32 kHz crystal models at the far side
`timescale 1ns/10ps
module scg_osc_model #(
  parameter int WDT_HALF = 1007,
  parameter int XT_HALF = 1013
) (
  output logic wdt_osc_pin,
  output logic xtal32_pin
);
  // Both run free; far faster than real parts to keep runs short
  initial begin
    wdt_osc_pin = 1'b0;
    forever #(WDT_HALF) wdt_osc_pin = ~wdt_osc_pin;
  end
  initial begin
    xtal32_pin = 1'b1;
    forever #(XT_HALF) xtal32_pin = ~xtal32_pin;
  end
endmodule

// ### verification/scg_clock_gen_asserts.sv
// Port-level concurrent checks for the clock generator
`timescale 1ns/10ps
module scg_clock_gen_asserts (
  input logic clk_sys,
  input logic sys_rst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic core_clock_tick,
  input logic program_store_clock_tick,
  input logic async_timer_clock_tick,
  input logic execution_enable
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ==========
  // Bus
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_resp;
    s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response mistimed");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error read carries data");
  // ==========
  // Clock domains
  property p_store_core;
    core_clock_tick == program_store_clock_tick;
  endproperty
  a_store_core: assert property (p_store_core)
    else $error("program store tick differs from core tick");
  property p_core_exec;
    core_clock_tick |-> execution_enable;
  endproperty
  a_core_exec: assert property (p_core_exec)
    else $error("core tick while core halted");
  property p_rst_hold;
    $fell(sys_rst) |-> !execution_enable [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("execution before reset delay");
  property p_async_gap;
    async_timer_clock_tick |=> !async_timer_clock_tick [*3];
  endproperty
  a_async_gap: assert property (p_async_gap)
    else $error("async tick faster than crystal");
endmodule
bind scg_clock_gen scg_clock_gen_asserts i_scg_clock_gen_asserts (.*);

// ### verification/scg_clock_gen_tb.sv
// Self-checking bench for the clock generator
`timescale 1ns/10ps
`include "scg_map.svh"
module scg_clock_gen_tb;
  logic clk_sys, sys_rst, reset_delay_fuse;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, source_select_field;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ext_int_async_pin, twi_addr_match_pin;
  logic wdt_osc_pin, xtal32_pin, execution_enable, core_clock_tick;
  logic peripheral_clock_tick, program_store_clock_tick;
  logic converter_clock_tick, async_timer_clock_tick;
  logic [3:0] seen;
  logic [2:0] gate_tab [6] = '{3'h7, 3'h3, 3'h0, 3'h1, 3'h0, 3'h1};
  int gd [2] = '{0, 127};
  int miscompares = 0;
  int check_count = 0;
  int c;
  // Small delay counts keep each boot to a few hundred cycles
  scg_clock_gen #(.RST_DLY_SHORT(17'h0_0008), .RST_DLY_LONG(17'h0_0010),
    .STARTUP_XTAL(16'h0010)) i_scg_clock_gen (.*);
  scg_osc_model i_scg_osc_model (.*);
  always #50 clk_sys = ~clk_sys;
  // ==========
  // Tasks
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(string nm);
    chk(nm, 1, 0);
    end_sim();
  endtask
  // Ready is raised late on purpose so the answer has to stand
  task automatic wr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 3) s_axi_bready <= 1'b1;
      if (n > 200) hang("write");
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 2) s_axi_rready <= 1'b1;
      if (n > 200) hang("read");
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic gap(output int g);
    int n;
    n = 0;
    g = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (core_clock_tick !== 1'b1 && n < 300);
    do begin
      @(posedge clk_sys);
      g++;
    end while (core_clock_tick !== 1'b1 && g < 300);
    if (n >= 300 || g >= 300) hang("tick");
    chk("domains", 3, {peripheral_clock_tick, converter_clock_tick});
  endtask
  task automatic boot(logic [3:0] sel, logic fz);
    sys_rst <= 1'b1;
    source_select_field <= sel;
    reset_delay_fuse <= fz;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  task automatic wait_run;
    c = 0;
    while (execution_enable !== 1'b1) begin
      @(posedge clk_sys);
      c++;
      if (c > 2000) hang("run");
    end
  endtask
  function automatic logic [2:0] cls(logic [3:0] s);
    return s > 9 ? 3'h0 : s == 9 ? 3'h1 : s > 4 ? 3'h2 : s > 0 ? 3'h3 : 3'h4;
  endfunction
  // ==========
  // Sequence
  initial begin
    {clk_sys, s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {ext_int_async_pin, twi_addr_match_pin, source_select_field} = '0;
    {sys_rst, reset_delay_fuse} = 2'h3;
    s_axi_wstrb = 4'hF;
    @(posedge clk_sys);
    for (int s = 0; s < 16; s++) begin
      boot(s[3:0], 1'b1);
      rdr(`SCG_ADDR_STATUS, rd, rsp);
      chk("source", {cls(s[3:0]), 2'h0}, rd & 32'h0000_001F);
    end
    boot(4'hF, 1'b1);
    wait_run();
    chk("short delay", 1, c > 150 && c < 316);
    boot(4'hF, 1'b0);
    wait_run();
    chk("long delay", 1, c > 316);
    rdr(`SCG_ADDR_DIVCTL, rd, rsp);
    chk("divider reset", 0, rd);
    chk("read resp", `SCG_RESP_OKAY, rsp);
    rdr(`SCG_ADDR_STATUS, rd, rsp);
    chk("run state", 2, rd & 32'hFFFF_FF1F);
    foreach (gd[i]) begin
      wr(`SCG_ADDR_DIVCTL, {24'h0, 1'b1, gd[i][6:0]}, rsp);
      chk("write resp", `SCG_RESP_OKAY, rsp);
      gap(c);
      gap(c);
      chk("divided gap", 129 - gd[i], c);
    end
    wr(`SCG_ADDR_DIVCTL, 32'h0000_0005, rsp);
    rdr(`SCG_ADDR_DIVCTL, rd, rsp);
    chk("factor kept", 32'h0000_007F, rd);
    rdr(4'hC, rd, rsp);
    chk("unmapped resp", `SCG_RESP_SLVERR, rsp);
    chk("unmapped data", 0, rd);
    wr(4'hC, 32'h0000_0080, rsp);
    chk("unmapped wresp", `SCG_RESP_SLVERR, rsp);
    for (int m = 0; m < 6; m++) begin
      wr(`SCG_ADDR_SLEEP, {28'h0, 1'b1, m[2:0]}, rsp);
      repeat (4) @(posedge clk_sys);
      seen = '0;
      repeat (60) begin
        @(posedge clk_sys);
        seen |= {core_clock_tick, peripheral_clock_tick,
          converter_clock_tick, async_timer_clock_tick};
      end
      chk("gating", gate_tab[m], seen);
      chk("halted", 0, execution_enable);
      if (m[0])
        ext_int_async_pin <= 1'b1;
      else
        twi_addr_match_pin <= 1'b1;
      wait_run();
      if (m == 2 || m == 3) chk("wake count", 1, c >= 16);
      else chk("fast wake", 1, c < 16);
      {ext_int_async_pin, twi_addr_match_pin} <= 2'h0;
      repeat (6) @(posedge clk_sys);
    end
    rdr(`SCG_ADDR_SLEEP, rd, rsp);
    chk("sleep reg", 5, rd);
    end_sim();
  end
endmodule
